// *** rtl/rtc_link_pkg.sv ***
// Constants, types and timing counts shared by both ends of the two-wire link.
// Assumes the master end runs on a 250 MHz clock and the slave end oversamples the bus.
//
// Contract
// - Master makes clock, START, STOP; slave only.
// - Master starts only when bus idle.
// - Data changes only while clock low.
// - Slave detects START: data falls, clock high.
// - Slave detects STOP: data rises, clock high.
// - Slave accepts any byte count.
// - Bytes are MSB first, ninth clock acknowledges.
// - Standard speed only, 100 kHz at most.
// - Ninth pulse; acknowledger holds data low.
// - Slave releases data on master not-acknowledge.
// - First byte is address 1101000 plus direction.
// - Matching address acknowledged in next slot.
// - First written byte loads register pointer.
// - Further written bytes stored, acknowledged, pointer advances.
// - Direction one: acknowledge, send from pointer.
// - Read without pointer write uses retained pointer.
// - Pointer advances after each byte sent.
// - Master acknowledges all but last read byte.
// - Repeated START accepted in place of STOP.
// - Pointer wraps from top to zero.
// - Low eight locations calendar, rest memory.
// - Power fail aborts access, clears pointer.
package rtc_link_pkg;

   localparam int BYTE_W = 8;
   localparam int PTR_W = 6;
   localparam int MEM_DEPTH = 64;
   localparam int FILTER_LEN = 3;

   localparam logic [6:0] SLAVE_ADDR = 7'h68;
   localparam logic [5:0] PTR_RESET = 6'h00;
   localparam logic [5:0] SRAM_FIRST = 6'h08;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   localparam int CLK_MHZ = 250;
   localparam int SCL_KHZ = 100;
   // One quarter of a bus clock period, in master clock cycles.
   localparam int SCL_QUARTER_CYC = (CLK_MHZ * 1000) / (SCL_KHZ * 4);

   localparam logic [5:0] START_STEP_LAST = 6'h03;
   localparam logic [5:0] STOP_STEP_LAST = 6'h05;
   localparam logic [5:0] BYTE_STEP_LAST = 6'h23;

   typedef enum logic [2:0] {
      DEV_IDLE = 3'b000,
      DEV_ADDR = 3'b001,
      DEV_PTR = 3'b010,
      DEV_WDATA = 3'b011,
      DEV_RDATA = 3'b100
   } dev_state_type;

   typedef enum logic [1:0] {
      OP_START = 2'b00,
      OP_WRITE = 2'b01,
      OP_READ = 2'b10,
      OP_STOP = 2'b11
   } op_type;

   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_HOLD = 3'b001,
      M_START = 3'b010,
      M_STOP = 3'b011,
      M_WRITE = 3'b100,
      M_READ = 3'b101
   } mst_state_type;

endpackage : rtc_link_pkg

// *** rtl/rtc_link_if.sv ***
// Two-wire bus between the master end and the slave end.
// Both lines are open drain with a pull-up; the wire levels are resolved here.
`timescale 1ns/1ps
interface rtc_link_if;
   logic scl_oe_m;
   logic scl_o_m;
   logic sda_oe_m;
   logic sda_o_m;
   logic sda_oe_d;
   logic sda_o_d;
   logic scl;
   logic sda;

   assign scl = !(scl_oe_m && !scl_o_m);
   assign sda = !(sda_oe_m && !sda_o_m) && !(sda_oe_d && !sda_o_d);

   modport master (output scl_oe_m, output scl_o_m, output sda_oe_m, output sda_o_m, input scl, input sda);
   modport device (output sda_oe_d, output sda_o_d, input scl, input sda);
endinterface : rtc_link_if

// *** rtl/rtc_link_device.sv ***
// Slave end of the two-wire link: address decode, register pointer and a
// 64-byte register space, with written bytes reported to the clk domain.
// Assumes link_clk oversamples the bus far faster than the bus clock.
`timescale 1ns/1ps
module rtc_link_device #(
   parameter int FILTER = rtc_link_pkg::FILTER_LEN
) (
   input wire logic link_clk,
   input wire logic link_reset,
   input wire logic clk,
   input wire logic reset,
   rtc_link_if.device link,
   input wire logic power_fail,
   output logic wr_valid,
   output logic [rtc_link_pkg::PTR_W-1:0] wr_addr,
   output logic [rtc_link_pkg::BYTE_W-1:0] wr_data,
   output logic wr_sram
);
   import rtc_link_pkg::*;

   function automatic logic is_rx(input dev_state_type s);
      is_rx = (s == DEV_ADDR) || (s == DEV_PTR) || (s == DEV_WDATA);
   endfunction : is_rx

   logic scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff;
   logic pf_s1_ff, pf_s2_ff;
   logic [FILTER-1:0] scl_h_ff, sda_h_ff;
   logic scl_f_ff, sda_f_ff, scl_p_ff, sda_p_ff;
   logic scl_rise, scl_fall, start_seen, stop_seen;

   dev_state_type state_ff;
   logic [3:0] bit_ff;
   logic ack_ff, rw_ff, nack_ff, sda_oe_ff;
   logic [BYTE_W-1:0] shift_ff, tx_ff;
   logic [PTR_W-1:0] ptr_ff;
   logic [BYTE_W-1:0] mem [MEM_DEPTH];

   logic busy, addr_match, bit_rise, byte_end, ack_end, tx_fall, load_rd, store;

   logic ev_tgl_ff;
   logic [PTR_W-1:0] ev_addr_ff;
   logic [BYTE_W-1:0] ev_data_ff;
   logic tg_s1_ff, tg_s2_ff, tg_p_ff;
   logic wr_valid_ff, wr_sram_ff;
   logic [PTR_W-1:0] wr_addr_ff;
   logic [BYTE_W-1:0] wr_data_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Bus sampling on the link clock.

   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
      end else begin
         scl_s1_ff <= link.scl;
         scl_s2_ff <= scl_s1_ff;
         sda_s1_ff <= link.sda;
         sda_s2_ff <= sda_s1_ff;
      end
   end

   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         pf_s1_ff <= 1'b0;
         pf_s2_ff <= 1'b0;
      end else begin
         pf_s1_ff <= power_fail;
         pf_s2_ff <= pf_s1_ff;
      end
   end

   // Both lines pass the same filter, so their relative timing is kept and a
   // glitch shorter than FILTER samples cannot fake a START or STOP.
   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         scl_h_ff <= {FILTER{1'b1}};
         sda_h_ff <= {FILTER{1'b1}};
         scl_f_ff <= 1'b1;
         sda_f_ff <= 1'b1;
         scl_p_ff <= 1'b1;
         sda_p_ff <= 1'b1;
      end else begin
         scl_h_ff <= {scl_h_ff[FILTER-2:0], scl_s2_ff};
         sda_h_ff <= {sda_h_ff[FILTER-2:0], sda_s2_ff};
         if (&scl_h_ff) begin
            scl_f_ff <= 1'b1;
         end else if (~|scl_h_ff) begin
            scl_f_ff <= 1'b0;
         end
         if (&sda_h_ff) begin
            sda_f_ff <= 1'b1;
         end else if (~|sda_h_ff) begin
            sda_f_ff <= 1'b0;
         end
         scl_p_ff <= scl_f_ff;
         sda_p_ff <= sda_f_ff;
      end
   end

   assign scl_rise = scl_f_ff && !scl_p_ff;
   assign scl_fall = !scl_f_ff && scl_p_ff;
   assign start_seen = scl_f_ff && scl_p_ff && sda_p_ff && !sda_f_ff;
   assign stop_seen = scl_f_ff && scl_p_ff && !sda_p_ff && sda_f_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Byte framing strobes.

   assign busy = (state_ff != DEV_IDLE);
   assign addr_match = (shift_ff[7:1] == SLAVE_ADDR);
   assign bit_rise = scl_rise && busy && !ack_ff && (bit_ff != BITS_PER_BYTE);
   assign byte_end = scl_fall && busy && !ack_ff && (bit_ff == BITS_PER_BYTE);
   assign ack_end = scl_fall && busy && ack_ff;
   assign tx_fall = scl_fall && (state_ff == DEV_RDATA) && !ack_ff && (bit_ff != 4'h0) &&
                    (bit_ff != BITS_PER_BYTE);
   assign load_rd = ack_end && (((state_ff == DEV_ADDR) && rw_ff) ||
                                ((state_ff == DEV_RDATA) && !nack_ff));
   assign store = byte_end && (state_ff == DEV_WDATA);

   ////////////////////////////////////////////////////////////////////////////
   // Transfer state.

   always_ff @(posedge link_clk) begin
      if (link_reset || pf_s2_ff) begin
         state_ff <= DEV_IDLE;
         bit_ff <= 4'h0;
         ack_ff <= 1'b0;
         rw_ff <= 1'b0;
         nack_ff <= 1'b0;
         shift_ff <= 8'h00;
      end else if (start_seen) begin
         state_ff <= DEV_ADDR;
         bit_ff <= 4'h0;
         ack_ff <= 1'b0;
      end else if (stop_seen) begin
         state_ff <= DEV_IDLE;
         bit_ff <= 4'h0;
         ack_ff <= 1'b0;
      end else begin
         if (bit_rise) begin
            bit_ff <= bit_ff + 4'h1;
            if (is_rx(state_ff)) begin
               shift_ff <= {shift_ff[6:0], sda_f_ff};
            end
         end
         if (scl_rise && ack_ff) begin
            nack_ff <= sda_f_ff;
         end
         if (byte_end) begin
            if (state_ff == DEV_ADDR) begin
               rw_ff <= shift_ff[0];
               ack_ff <= addr_match;
               if (!addr_match) begin
                  state_ff <= DEV_IDLE;
               end
            end else begin
               ack_ff <= 1'b1;
            end
         end
         if (ack_end) begin
            ack_ff <= 1'b0;
            bit_ff <= 4'h0;
            case (state_ff)
               DEV_ADDR: begin
                  state_ff <= rw_ff ? DEV_RDATA : DEV_PTR;
               end
               DEV_PTR: begin
                  state_ff <= DEV_WDATA;
               end
               DEV_WDATA: begin
                  state_ff <= DEV_WDATA;
               end
               DEV_RDATA: begin
                  if (nack_ff) begin
                     state_ff <= DEV_IDLE;
                  end
               end
               default: begin
                  state_ff <= DEV_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register pointer and register space.

   // The pointer is not touched by START, so a read that skips the pointer
   // write continues where the last access left off.
   always_ff @(posedge link_clk) begin
      if (link_reset || pf_s2_ff) begin
         ptr_ff <= PTR_RESET;
      end else if (byte_end && (state_ff == DEV_PTR)) begin
         ptr_ff <= shift_ff[PTR_W-1:0];
      end else if (store || load_rd) begin
         ptr_ff <= ptr_ff + 6'h01;
      end
   end

   // Contents are undefined after power-up; software must initialise them.
   always_ff @(posedge link_clk) begin
      if (store) begin
         mem[ptr_ff] <= shift_ff;
      end
   end

   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         tx_ff <= 8'h00;
      end else if (load_rd) begin
         tx_ff <= mem[ptr_ff];
      end else if (tx_fall) begin
         tx_ff <= {tx_ff[6:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data line drive, changed just after a falling clock, or released at any time by power fail.

   always_ff @(posedge link_clk) begin
      if (link_reset || pf_s2_ff || start_seen || stop_seen) begin
         sda_oe_ff <= 1'b0;
      end else if (byte_end) begin
         sda_oe_ff <= (state_ff != DEV_RDATA) && ((state_ff != DEV_ADDR) || addr_match);
      end else if (ack_end) begin
         sda_oe_ff <= load_rd ? !mem[ptr_ff][7] : 1'b0;
      end else if (tx_fall) begin
         sda_oe_ff <= !tx_ff[6];
      end
   end

   assign link.sda_o_d = 1'b0;
   assign link.sda_oe_d = sda_oe_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Written bytes handed to the clk domain by a toggle; the words stay put
   // for at least nine bus clocks, far longer than the crossing takes.

   always_ff @(posedge link_clk) begin
      if (link_reset) begin
         ev_tgl_ff <= 1'b0;
         ev_addr_ff <= 6'h00;
         ev_data_ff <= 8'h00;
      end else if (store) begin
         ev_tgl_ff <= !ev_tgl_ff;
         ev_addr_ff <= ptr_ff;
         ev_data_ff <= shift_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tg_s1_ff <= 1'b0;
         tg_s2_ff <= 1'b0;
         tg_p_ff <= 1'b0;
      end else begin
         tg_s1_ff <= ev_tgl_ff;
         tg_s2_ff <= tg_s1_ff;
         tg_p_ff <= tg_s2_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_valid_ff <= 1'b0;
         wr_addr_ff <= 6'h00;
         wr_data_ff <= 8'h00;
         wr_sram_ff <= 1'b0;
      end else begin
         wr_valid_ff <= tg_s2_ff ^ tg_p_ff;
         if (tg_s2_ff ^ tg_p_ff) begin
            wr_addr_ff <= ev_addr_ff;
            wr_data_ff <= ev_data_ff;
            wr_sram_ff <= (ev_addr_ff >= SRAM_FIRST);
         end
      end
   end

   assign wr_valid = wr_valid_ff;
   assign wr_addr = wr_addr_ff;
   assign wr_data = wr_data_ff;
   assign wr_sram = wr_sram_ff;

endmodule : rtc_link_device

// *** rtl/rtc_link_master.sv ***
// Master end of the two-wire link: makes the bus clock by dividing clk and
// runs one byte-level command at a time.
// Assumes a single slave that never stretches the clock.
`timescale 1ns/1ps
module rtc_link_master #(
   parameter int QUARTER_CYCLES = rtc_link_pkg::SCL_QUARTER_CYC
) (
   input wire logic clk,
   input wire logic reset,
   rtc_link_if.master link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire rtc_link_pkg::op_type cmd_op,
   input wire logic [rtc_link_pkg::BYTE_W-1:0] cmd_data,
   input wire logic cmd_last,
   output logic rsp_valid,
   output logic [rtc_link_pkg::BYTE_W-1:0] rsp_data,
   output logic rsp_nack
);
   import rtc_link_pkg::*;

   localparam logic [15:0] QCNT_LAST = 16'(QUARTER_CYCLES - 1);

   function automatic logic [5:0] last_step(input mst_state_type s);
      case (s)
         M_START: last_step = START_STEP_LAST;
         M_STOP: last_step = STOP_STEP_LAST;
         default: last_step = BYTE_STEP_LAST;
      endcase
   endfunction : last_step

   logic scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff;
   mst_state_type state_ff;
   logic [15:0] qcnt_ff;
   logic [5:0] step_ff;
   logic [BYTE_W-1:0] shift_ff;
   logic last_ff, nack_ff, scl_oe_ff, sda_oe_ff, cmd_ready_ff;
   logic rsp_valid_ff, rsp_nack_ff;
   logic [BYTE_W-1:0] rsp_data_ff;
   logic tick, running, accept, refused, done, bus_free;
   logic [1:0] q;
   logic [3:0] bitn;

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
      end else begin
         scl_s1_ff <= link.scl;
         scl_s2_ff <= scl_s1_ff;
         sda_s1_ff <= link.sda;
         sda_s2_ff <= sda_s1_ff;
      end
   end

   assign tick = (qcnt_ff == QCNT_LAST);
   assign running = (state_ff != M_IDLE) && (state_ff != M_HOLD);
   assign accept = cmd_valid && cmd_ready_ff;
   assign refused = accept && (state_ff == M_IDLE) && (cmd_op != OP_START);
   assign done = running && tick && (step_ff == last_step(state_ff));
   assign bus_free = scl_s2_ff && sda_s2_ff;
   assign q = step_ff[1:0];
   assign bitn = step_ff[5:2];

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencing.

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= M_IDLE;
      end else if (accept && !refused) begin
         case (cmd_op)
            OP_START: state_ff <= M_START;
            OP_STOP: state_ff <= M_STOP;
            OP_WRITE: state_ff <= M_WRITE;
            OP_READ: state_ff <= M_READ;
            default: state_ff <= M_IDLE;
         endcase
      end else if (done) begin
         state_ff <= (state_ff == M_STOP) ? M_IDLE : M_HOLD;
      end
   end

   // A new START from idle waits until both lines are seen high.
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_ready_ff <= 1'b0;
      end else begin
         cmd_ready_ff <= !accept && !done && ((state_ff == M_HOLD) || ((state_ff == M_IDLE) && bus_free));
      end
   end

   always_ff @(posedge clk) begin
      if (reset || accept || !running) begin
         qcnt_ff <= 16'h0000;
         step_ff <= 6'h00;
      end else if (tick) begin
         qcnt_ff <= 16'h0000;
         step_ff <= step_ff + 6'h01;
      end else begin
         qcnt_ff <= qcnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         shift_ff <= 8'h00;
         last_ff <= 1'b0;
         nack_ff <= 1'b0;
      end else if (accept) begin
         shift_ff <= cmd_data;
         last_ff <= cmd_last;
         nack_ff <= 1'b0;
      end else if (running && tick) begin
         if ((state_ff == M_READ) && (q == 2'h2) && (bitn != BITS_PER_BYTE)) begin
            shift_ff <= {shift_ff[6:0], sda_s2_ff};
         end
         if ((state_ff == M_WRITE) && (q == 2'h3) && (bitn != BITS_PER_BYTE)) begin
            shift_ff <= {shift_ff[6:0], 1'b0};
         end
         if ((state_ff == M_WRITE) && (q == 2'h2) && (bitn == BITS_PER_BYTE)) begin
            nack_ff <= sda_s2_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line drive: clock high on quarter 1, low on quarter 3; data set on quarter 0.

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_oe_ff <= 1'b0;
      end else if (running && tick) begin
         case (state_ff)
            M_START: begin
               if (step_ff == 6'h01) scl_oe_ff <= 1'b0;
               if (step_ff == 6'h03) scl_oe_ff <= 1'b1;
            end
            M_STOP: begin
               if (step_ff == 6'h01) scl_oe_ff <= 1'b0;
            end
            default: begin
               if (q == 2'h1) scl_oe_ff <= 1'b0;
               if (q == 2'h3) scl_oe_ff <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sda_oe_ff <= 1'b0;
      end else if (running && tick) begin
         case (state_ff)
            M_START: begin
               if (step_ff == 6'h00) sda_oe_ff <= 1'b0;
               if (step_ff == 6'h02) sda_oe_ff <= 1'b1;
            end
            M_STOP: begin
               if (step_ff == 6'h00) sda_oe_ff <= 1'b1;
               if (step_ff == 6'h02) sda_oe_ff <= 1'b0;
            end
            M_WRITE: begin
               if (q == 2'h0) sda_oe_ff <= (bitn != BITS_PER_BYTE) && !shift_ff[7];
            end
            default: begin
               if (q == 2'h0) sda_oe_ff <= (bitn == BITS_PER_BYTE) && !last_ff;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rsp_valid_ff <= 1'b0;
         rsp_data_ff <= 8'h00;
         rsp_nack_ff <= 1'b0;
      end else begin
         rsp_valid_ff <= done || refused;
         if (refused) begin
            rsp_data_ff <= 8'h00;
            rsp_nack_ff <= 1'b1;
         end else if (done) begin
            rsp_data_ff <= (state_ff == M_READ) ? shift_ff : 8'h00;
            rsp_nack_ff <= (state_ff == M_WRITE) && nack_ff;
         end
      end
   end

   assign link.scl_o_m = 1'b0;
   assign link.sda_o_m = 1'b0;
   assign link.scl_oe_m = scl_oe_ff;
   assign link.sda_oe_m = sda_oe_ff;
   assign cmd_ready = cmd_ready_ff;
   assign rsp_valid = rsp_valid_ff;
   assign rsp_data = rsp_data_ff;
   assign rsp_nack = rsp_nack_ff;

endmodule : rtc_link_master

// *** bench/rtc_link_asserts.sv ***
// Concurrent checks on the two-wire link between the master end and the slave end.
// Assumes it sits beside the interface and is clocked by the master's clk and reset.
`timescale 1ns/1ps
module rtc_link_asserts #(
   parameter int QUARTER_CYCLES = rtc_link_pkg::SCL_QUARTER_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_oe_m,
   input wire logic scl_o_m,
   input wire logic sda_oe_m,
   input wire logic sda_o_m,
   input wire logic sda_oe_d,
   input wire logic sda_o_d,
   input wire logic scl,
   input wire logic sda
);
   import rtc_link_pkg::*;
   // A small margin keeps the span check clear of the one-cycle edge detection delay.
   localparam int MIN_SPAN = 2 * QUARTER_CYCLES - 4;
   logic scl_ff;
   logic [15:0] span_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      scl_ff <= scl;
   end

   always_ff @(posedge clk) begin
      if (reset || scl != scl_ff) begin
         span_ff <= 16'h0000;
      end else if (span_ff != 16'hffff) begin
         span_ff <= span_ff + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   chk_master_open_drain: assert property (scl_o_m == 1'b0 && sda_o_m == 1'b0)
      else $error("master drives a line high");
   chk_slave_open_drain: assert property (sda_o_d == 1'b0)
      else $error("slave drives data high");
   chk_slave_edge_low: assert property ($changed(sda_oe_d) |-> !scl && !$past(scl))
      else $error("slave changed data while clock high");
   chk_ack_held_low: assert property ($rose(scl) && sda_oe_d |-> (!sda)[*8])
      else $error("acknowledge not held low");
   chk_bus_clock_span: assert property (scl != scl_ff |-> span_ff >= MIN_SPAN)
      else $error("bus clock phase too short");
   chk_start_hold: assert property ($fell(sda) && scl |-> scl[*8])
      else $error("start hold too short");
   chk_stop_bus_free: assert property ($rose(sda) && scl |-> (scl && sda)[*8])
      else $error("bus not free after stop");
   chk_no_contention: assert property (scl |-> !(sda_oe_d && sda_oe_m))
      else $error("both ends pull data while clock high");

   cover property ($rose(scl) && sda_oe_d);
   cover property ($fell(sda) && scl);
   cover property ($rose(sda) && scl);
endmodule : rtc_link_asserts

// *** bench/rtc_serial_bus_slave_port_bench.sv ***
// Self-checking bench: master end and slave end joined by the link interface.
// Assumes the master's command port and the slave's write report port are the only user sides.
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("mismatch %s expected %h seen %h", what, exp, got); end end
module rtc_serial_bus_slave_port_bench;
   import rtc_link_pkg::*;
   // A short quarter keeps the run brief while the slave's filter latency stays well inside it.
   localparam int QC = 40;
   logic clk = 1'b0, link_clk = 1'b0, reset = 1'b1, link_reset = 1'b1, power_fail = 1'b0;
   logic cmd_valid = 1'b0, cmd_last = 1'b0, cmd_ready, rsp_valid, rsp_nack, wr_valid, wr_sram, nk;
   op_type cmd_op = OP_START;
   logic [7:0] cmd_data = 8'h00, rsp_data, wr_data, rd;
   logic [7:0] wd[3] = '{8'ha1, 8'hb2, 8'hc3};
   logic [5:0] wr_addr;
   logic [8:0] wire_bits = 9'h000;
   logic [14:0] wq[$];
   int error_cnt = 0, total_checks = 0, cyc = 0;

   always #2 clk = ~clk;
   initial begin
      #1.7;
      forever #6 link_clk = ~link_clk;
   end

   rtc_link_if link ();
   rtc_link_master #(.QUARTER_CYCLES(QC)) rtc_link_master_i (.clk(clk), .reset(reset), .link(link),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
      .cmd_last(cmd_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
   rtc_link_device rtc_link_device_i (.link_clk(link_clk), .link_reset(link_reset), .clk(clk),
      .reset(reset), .link(link), .power_fail(power_fail), .wr_valid(wr_valid), .wr_addr(wr_addr),
      .wr_data(wr_data), .wr_sram(wr_sram));
   rtc_link_asserts #(.QUARTER_CYCLES(QC)) rtc_link_asserts_i (.clk(clk), .reset(reset),
      .scl_oe_m(link.scl_oe_m), .scl_o_m(link.scl_o_m), .sda_oe_m(link.sda_oe_m),
      .sda_o_m(link.sda_o_m), .sda_oe_d(link.sda_oe_d), .sda_o_d(link.sda_o_d),
      .scl(link.scl), .sda(link.sda));

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge link.scl) wire_bits <= {wire_bits[7:0], link.sda};
   always @(posedge clk) if (wr_valid === 1'b1) wq.push_back({wr_sram, wr_addr, wr_data});
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   function automatic logic [14:0] pop();
      return (wq.size() > 0) ? wq.pop_front() : 15'h7fff;
   endfunction : pop

   // Request is held until cmd_ready is seen at an edge; the answer is taken at the rsp_valid edge.
   task automatic xfer(input op_type op, input logic [7:0] d = 8'h00, input logic last = 1'b0);
      int n;
      n = 0;
      cmd_op <= op;
      cmd_data <= d;
      cmd_last <= last;
      cmd_valid <= 1'b1;
      do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 5000);
      cmd_valid <= 1'b0;
      do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 5000);
      rd = rsp_data;
      nk = rsp_nack;
      // A command that never completes is a failure in its own right, not a stale answer.
      if (n >= 5000) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask : xfer

   ////////////////////////////////////////////////////////////////////////////////
   task automatic write_wrap();
      xfer(OP_START);
      xfer(OP_WRITE, 8'hd0);
      `CHECK("address ack", 1'b0, nk)
      `CHECK("address bits on wire", 9'h1a0, wire_bits)
      xfer(OP_WRITE, 8'hfe);
      `CHECK("pointer ack", 1'b0, nk)
      foreach (wd[i]) begin
         xfer(OP_WRITE, wd[i]);
         `CHECK("data ack", 1'b0, nk)
      end
      xfer(OP_STOP);
      `CHECK("store at 3e", {1'b1, 6'h3e, 8'ha1}, pop())
      `CHECK("store at 3f", {1'b1, 6'h3f, 8'hb2}, pop())
      `CHECK("store at 00", {1'b0, 6'h00, 8'hc3}, pop())
   endtask : write_wrap

   task automatic read_retained();
      xfer(OP_START);
      xfer(OP_WRITE, 8'hd0);
      xfer(OP_WRITE, 8'h3f);
      xfer(OP_STOP);
      xfer(OP_START);
      xfer(OP_WRITE, 8'hd1);
      `CHECK("read address ack", 1'b0, nk)
      xfer(OP_READ);
      `CHECK("read from 3f", 8'hb2, rd)
      xfer(OP_READ, 8'h00, 1'b1);
      `CHECK("read wraps to 00", 8'hc3, rd)
      `CHECK("read bits on wire", 8'hc3, wire_bits[8:1])
      `CHECK("last byte not acked", 1'b1, wire_bits[0])
      xfer(OP_STOP);
      `CHECK("no store on read", 0, wq.size())
   endtask : read_retained

   task automatic repeated_start();
      xfer(OP_START);
      xfer(OP_WRITE, 8'hd0);
      xfer(OP_WRITE, 8'h3e);
      xfer(OP_START);
      xfer(OP_WRITE, 8'hd1);
      `CHECK("ack after repeated start", 1'b0, nk)
      xfer(OP_READ, 8'h00, 1'b1);
      `CHECK("read after repeated start", 8'ha1, rd)
      xfer(OP_START);
      xfer(OP_WRITE, 8'hd1);
      xfer(OP_READ, 8'h00, 1'b1);
      `CHECK("pointer advanced by read", 8'hb2, rd)
      xfer(OP_STOP);
   endtask : repeated_start

   task automatic foreign_addr();
      xfer(OP_WRITE, 8'h55);
      `CHECK("write refused in idle", 1'b1, nk)
      xfer(OP_START);
      xfer(OP_WRITE, 8'ha0);
      `CHECK("other address not acked", 1'b1, nk)
      xfer(OP_WRITE, 8'h55);
      `CHECK("ignored until start", 1'b1, nk)
      xfer(OP_START);
      xfer(OP_WRITE, 8'hd3);
      `CHECK("near address not acked", 1'b1, nk)
      xfer(OP_STOP);
      `CHECK("nothing stored", 0, wq.size())
   endtask : foreign_addr

   task automatic power_abort();
      xfer(OP_START);
      xfer(OP_WRITE, 8'hd0);
      xfer(OP_WRITE, 8'h10);
      power_fail <= 1'b1;
      xfer(OP_WRITE, 8'h77);
      `CHECK("byte refused in power fail", 1'b1, nk)
      power_fail <= 1'b0;
      xfer(OP_STOP);
      `CHECK("no store in power fail", 0, wq.size())
      xfer(OP_START);
      xfer(OP_WRITE, 8'hd1);
      xfer(OP_READ, 8'h00, 1'b1);
      `CHECK("pointer cleared", 8'hc3, rd)
      xfer(OP_STOP);
   endtask : power_abort

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (8) @(posedge link_clk);
      link_reset <= 1'b0;
   end

   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      wait (link_reset == 1'b0);
      @(posedge clk);
      write_wrap();
      read_retained();
      repeated_start();
      foreign_addr();
      power_abort();
      tally_and_finish();
   end
endmodule : rtc_serial_bus_slave_port_bench
